// ==== rtl/temp_loop_pkg.sv ====
package temp_loop_pkg;
  // Word offsets of the input words
  localparam logic [7:0] OFS_LOOP4_SET_POINT = 8'h10;
  localparam logic [7:0] OFS_DECIMAL_AND_SETTING_ERROR = 8'h11;
  localparam logic [7:0] OFS_LOOP3_STATUS_FLAGS = 8'h12;
  // Field positions, decimal and setting-error word
  localparam int DP_LOOP3_LSB = 12;
  localparam int DP_LOOP4_LSB = 8;
  localparam int SE_LOOP3_LSB = 4;
  localparam int SE_LOOP4_LSB = 0;
  // Field positions, loop 3 status word
  localparam int BIT_SAVE_DONE = 15;
  localparam int BIT_SENSOR_ERR = 14;
  localparam int BIT_UNUSED = 13;
  localparam int BIT_FATAL_ERR = 12;
  localparam int BIT_STANDBY = 11;
  localparam int BIT_PID_CALC = 10;
  // Host output word n+2 bit that starts a save
  localparam int BIT_SAVE_REQ = 15;
  // Encodings
  localparam logic [3:0] BCD_NEG_DIGIT = 4'hF;
  localparam logic [15:0] PV_RANGE_ERR = 16'hCCCC;
  localparam logic [15:0] RESET_WORD = 16'h0000;
  localparam logic [3:0] RESET_NIBBLE = 4'h0;
  localparam logic [1:0] RESET_STATE = 2'b00;
  typedef enum logic [1:0] {
    SAVE_IDLE = 2'b00,
    SAVE_BUSY = 2'b01,
    SAVE_DONE = 2'b10
  } save_state_t;
endpackage

// ==== rtl/temp_loop_status_words.sv ====
`timescale 1ns/1ps
// Summary of operation
// R01: A negative loop 4 set point in BCD carries F in its top nibble.
// R02: Decimal places sit in bits 12-15 (loop 3) and 8-11 (loop 4), 0 or 1.
// R03: Setting error numbers sit in bits 4-7 (loop 3) and 0-3 (loop 4).
// R04: Save-completed (bit 15) sets when the copy to nonvolatile ends.
// R05: Host bit 15 of output word n+2 starts the copy to nonvolatile.
// R06: Save-completed clears when the host raises the save request.
// R07: Save-completed is clear after power-up until a save finishes.
// R08: Sensor error (bit 14) sets on missing, broken or overrange sensor.
// R09: Fatal error (bit 12) sets on cold-junction fault or host watchdog.
// R10: Standby (bit 11) is set until the first refresh after start.
// R11: PID-calculated (bit 10) sets when autotuning updates the constants.
// R12: While PID-calculated is set the host's constants count as pending.
// R13: A change-PID request loads host constants and clears PID-calculated unless autotuning updates in the same cycle.
// R14: Clear PID-calculated means the host's constants have been taken.
// R15: An overrange sensor error forces the process value to CCCC.
// R16: Set point words are four BCD digits or 16-bit binary by format.
// R17: Bit 13 of the loop 3 status word always reads zero.
module temp_loop_status_words (
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic restart_in,
  input wire logic io_refresh_in,
  input wire logic [7:0] rd_addr_in,
  output logic [15:0] rd_data_out,
  input wire logic bcd_format_in,
  input wire logic signed [15:0] loop4_sp_value_in,
  input wire logic signed [15:0] loop3_pv_value_in,
  input wire logic [3:0] loop3_decimal_in,
  input wire logic [3:0] loop4_decimal_in,
  input wire logic [3:0] loop3_setting_err_in,
  input wire logic [3:0] loop4_setting_err_in,
  input wire logic [15:0] host_out_word_n2_in,
  output logic save_start_out,
  input wire logic save_done_in,
  input wire logic sensor_absent_in,
  input wire logic sensor_broken_in,
  input wire logic sensor_overrange_in,
  input wire logic cold_junction_fault_in,
  input wire logic host_watchdog_timer_err_in,
  input wire logic autotune_update_in,
  input wire logic change_pid_req_in,
  output logic pid_load_out,
  output logic pid_pending_out,
  output logic [15:0] loop3_pv_word_out
);
  import temp_loop_pkg::*;

  // ----------------------------------------------------------------
  // Set point and process value encoding
  // ----------------------------------------------------------------
  function automatic logic [15:0] encode_value(input logic bcd,
                                               input logic [15:0] v);
    logic [15:0] mag;
    logic [15:0] r;
    mag = v[15] ? 16'((~v) + 16'h0001) : v;
    r = RESET_WORD;
    if (bcd) begin
      r[3:0] = 4'(mag % 16'h000A);
      r[7:4] = 4'((mag / 16'h000A) % 16'h000A);
      r[11:8] = 4'((mag / 16'h0064) % 16'h000A);
      if (v[15]) begin
        r[15:12] = BCD_NEG_DIGIT; // [R01]
      end else begin
        r[15:12] = 4'((mag / 16'h03E8) % 16'h000A);
      end
    end else begin
      r = v; // [R16]
    end
    return r;
  endfunction

  logic [15:0] loop4_set_point;
  logic [15:0] decimal_and_setting_error;
  logic [15:0] loop3_status_flags;
  save_state_t save_state;
  logic save_req_q;
  logic change_req_q;
  logic save_done_flag;
  logic sensor_err;
  logic fatal_err;
  logic standby;
  logic pid_calc;
  logic save_rise;
  logic change_rise;

  assign save_rise = host_out_word_n2_in[BIT_SAVE_REQ] && !save_req_q;
  assign change_rise = change_pid_req_in && !change_req_q;

  // ----------------------------------------------------------------
  // Data words
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      loop4_set_point <= RESET_WORD;
      decimal_and_setting_error <= RESET_WORD;
      loop3_pv_word_out <= RESET_WORD;
    end else if (clk_en_in) begin
      loop4_set_point <= encode_value(bcd_format_in,
                                      loop4_sp_value_in); // [R16]
      decimal_and_setting_error[DP_LOOP3_LSB +: 4] <=
        loop3_decimal_in; // [R02]
      decimal_and_setting_error[DP_LOOP4_LSB +: 4] <=
        loop4_decimal_in; // [R02]
      decimal_and_setting_error[SE_LOOP3_LSB +: 4] <=
        loop3_setting_err_in; // [R03]
      decimal_and_setting_error[SE_LOOP4_LSB +: 4] <=
        loop4_setting_err_in; // [R03]
      if (sensor_overrange_in) begin
        loop3_pv_word_out <= PV_RANGE_ERR; // [R15]
      end else begin
        loop3_pv_word_out <= encode_value(bcd_format_in, loop3_pv_value_in);
      end
    end
  end

  // ----------------------------------------------------------------
  // Save sequence
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      save_state <= SAVE_IDLE;
      save_req_q <= 1'b0;
      save_start_out <= 1'b0;
    end else if (clk_en_in) begin
      save_req_q <= host_out_word_n2_in[BIT_SAVE_REQ];
      save_start_out <= 1'b0;
      case (save_state)
        SAVE_IDLE, SAVE_DONE: begin
          if (save_rise) begin
            save_state <= SAVE_BUSY; // [R05] [R06]
            save_start_out <= 1'b1;
          end
        end
        SAVE_BUSY: begin
          if (save_done_in) begin
            save_state <= SAVE_DONE; // [R04]
          end
        end
        default: begin
          save_state <= SAVE_IDLE;
        end
      endcase
    end
  end

  assign save_done_flag = (save_state == SAVE_DONE); // [R07]

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      sensor_err <= 1'b0;
      fatal_err <= 1'b0;
    end else if (clk_en_in) begin
      sensor_err <= sensor_absent_in || sensor_broken_in
                    || sensor_overrange_in; // [R08]
      fatal_err <= cold_junction_fault_in
                   || host_watchdog_timer_err_in; // [R09]
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      standby <= 1'b1;
    end else if (clk_en_in) begin
      if (restart_in) begin
        standby <= 1'b1; // [R10]
      end else if (io_refresh_in) begin
        standby <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      pid_calc <= 1'b0;
      change_req_q <= 1'b0;
      pid_load_out <= 1'b0;
    end else if (clk_en_in) begin
      change_req_q <= change_pid_req_in;
      pid_load_out <= change_rise; // [R13]
      if (autotune_update_in) begin
        pid_calc <= 1'b1; // [R11]
      end else if (change_rise) begin
        pid_calc <= 1'b0; // [R13]
      end
    end
  end

  assign pid_pending_out = pid_calc; // [R12] [R14]

  always_comb begin
    loop3_status_flags = RESET_WORD;
    loop3_status_flags[BIT_SAVE_DONE] = save_done_flag;
    loop3_status_flags[BIT_SENSOR_ERR] = sensor_err;
    loop3_status_flags[BIT_UNUSED] = 1'b0; // [R17]
    loop3_status_flags[BIT_FATAL_ERR] = fatal_err;
    loop3_status_flags[BIT_STANDBY] = standby;
    loop3_status_flags[BIT_PID_CALC] = pid_calc;
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!reset_n_in) begin
      rd_data_out <= RESET_WORD;
    end else if (clk_en_in) begin
      case (rd_addr_in)
        OFS_LOOP4_SET_POINT: rd_data_out <= loop4_set_point;
        OFS_DECIMAL_AND_SETTING_ERROR: begin
          rd_data_out <= decimal_and_setting_error;
        end
        OFS_LOOP3_STATUS_FLAGS: rd_data_out <= loop3_status_flags;
        default: rd_data_out <= RESET_WORD;
      endcase
    end
  end
endmodule

// ==== verif/tls_chk_assertions.sv ====
`timescale 1ns/1ps
module tls_chk
  import temp_loop_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic reset_n_in,
  input wire logic clk_en_in,
  input wire logic sensor_absent_in,
  input wire logic sensor_broken_in,
  input wire logic sensor_overrange_in,
  input wire logic cold_junction_fault_in,
  input wire logic host_watchdog_timer_err_in,
  input wire logic autotune_update_in,
  input wire logic change_pid_req_in,
  input wire logic save_start_out,
  input wire logic pid_load_out,
  input wire logic pid_pending_out,
  input wire logic [7:0] rd_addr_in,
  input wire logic [15:0] host_out_word_n2_in,
  input wire logic [15:0] rd_data_out,
  input wire logic [15:0] loop3_pv_word_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic st;
  logic sens;
  logic fat;
  assign st = clk_en_in && rd_addr_in == OFS_LOOP3_STATUS_FLAGS;
  assign sens = sensor_absent_in | sensor_broken_in | sensor_overrange_in;
  assign fat = cold_junction_fault_in | host_watchdog_timer_err_in;
  AST_BIT13_ZERO: assert property (st |=> !rd_data_out[BIT_UNUSED])
    else $error("status bit 13 set");
  AST_SENSOR: assert property ((clk_en_in ##1 st) |=>
    rd_data_out[BIT_SENSOR_ERR] == $past(sens, 2))
    else $error("sensor flag wrong");
  AST_FATAL: assert property ((clk_en_in ##1 st) |=>
    rd_data_out[BIT_FATAL_ERR] == $past(fat, 2))
    else $error("fatal flag wrong");
  AST_SAVE_CAUSE: assert property (save_start_out && $past(clk_en_in)
    && $past(clk_en_in, 2) |-> $past(host_out_word_n2_in[BIT_SAVE_REQ])
    && !$past(host_out_word_n2_in[BIT_SAVE_REQ], 2))
    else $error("save start without request edge");
  AST_SAVE_PULSE: assert property (clk_en_in && save_start_out
    |=> !save_start_out)
    else $error("save start too long");
  AST_PID_SET: assert property (clk_en_in && autotune_update_in
    |=> pid_pending_out)
    else $error("pid flag not set");
  AST_PID_LOAD: assert property (pid_load_out && $past(clk_en_in)
    && $past(clk_en_in, 2) |-> $past(change_pid_req_in)
    && !$past(change_pid_req_in, 2))
    else $error("pid load without request edge");
  AST_PID_CLEAR: assert property (pid_load_out
    && !$past(autotune_update_in) |-> !pid_pending_out)
    else $error("pid flag not cleared");
  AST_PV_RANGE: assert property (clk_en_in && sensor_overrange_in |=>
    loop3_pv_word_out == PV_RANGE_ERR)
    else $error("pv not forced");
  AST_UNMAPPED: assert property (clk_en_in
    && (rd_addr_in < OFS_LOOP4_SET_POINT
    || rd_addr_in > OFS_LOOP3_STATUS_FLAGS) |=> rd_data_out == RESET_WORD)
    else $error("unmapped read not zero");
  AST_FREEZE: assert property (!clk_en_in |=> $stable(rd_data_out))
    else $error("read data moved while frozen");
  cover property (save_start_out);
  cover property (pid_load_out);
  cover property (st ##1 rd_data_out[BIT_SAVE_DONE]);
endmodule
bind temp_loop_status_words tls_chk i_tls_chk (
  .sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in), .clk_en_in(clk_en_in),
  .sensor_absent_in(sensor_absent_in), .sensor_broken_in(sensor_broken_in),
  .sensor_overrange_in(sensor_overrange_in),
  .cold_junction_fault_in(cold_junction_fault_in),
  .host_watchdog_timer_err_in(host_watchdog_timer_err_in),
  .autotune_update_in(autotune_update_in),
  .change_pid_req_in(change_pid_req_in), .save_start_out(save_start_out),
  .pid_load_out(pid_load_out), .pid_pending_out(pid_pending_out),
  .rd_addr_in(rd_addr_in), .host_out_word_n2_in(host_out_word_n2_in),
  .rd_data_out(rd_data_out), .loop3_pv_word_out(loop3_pv_word_out));

// ==== verif/host_cpu_model.sv ====
`timescale 1ns/1ps
module host_cpu_model (
  input wire logic sys_clk_in,
  input wire logic save_req_in,
  input wire logic save_start_in,
  input wire logic [3:0] dly_in,
  output logic [15:0] host_word_out,
  output logic save_done_out
);
  logic [3:0] cnt = 4'h0;
  initial save_done_out = 1'b0;
  assign host_word_out = {save_req_in, 15'h0000};
  // Copy completes dly_in cycles after the start pulse
  always @(posedge sys_clk_in) begin
    save_done_out <= cnt == 4'h1;
    if (save_start_in) cnt <= dly_in;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  end
endmodule

// ==== verif/temp_loop_status_words_tb.sv ====
`timescale 1ns/1ps
module temp_loop_status_words_tb;
  import temp_loop_pkg::*;
  logic clk = 0, rst_n = 0, en = 1, rs = 0, rf = 0, fmt = 1;
  logic [7:0] addr = 8'h00;
  logic [15:0] sp = 16'h0000, rd, n2, pvw;
  logic [3:0] d3 = 0, d4 = 0, e3 = 0, e4 = 0, dly = 4'h1;
  logic ab = 0, br = 0, ov = 0, cj = 0, wd = 0, at = 0, cp = 0, sq = 0;
  logic ss, sd, pl, pp;
  int failures = 0, check_count = 0;
  typedef struct packed {
    logic f; logic [15:0] sp, dec; logic [4:0] er; logic [15:0] xsp, xst;
  } row_t;
  row_t rows [5] = '{
    '{1, 16'h04D2, 16'h10A3, 5'h00, 16'h1234, 16'h0000},
    '{1, 16'hFF85, 16'h010F, 5'h11, 16'hF123, 16'h5000},
    '{0, 16'hFFFB, 16'h1156, 5'h0A, 16'hFFFB, 16'h5000},
    '{0, 16'h0190, 16'h0000, 5'h04, 16'h0190, 16'h4000},
    '{1, 16'hFC19, 16'h1111, 5'h00, 16'hF999, 16'h0000}};
  temp_loop_status_words i_temp_loop_status_words (
    .sys_clk_in(clk), .reset_n_in(rst_n), .clk_en_in(en), .restart_in(rs),
    .io_refresh_in(rf), .rd_addr_in(addr), .rd_data_out(rd),
    .bcd_format_in(fmt), .loop4_sp_value_in(sp), .loop3_pv_value_in(sp),
    .loop3_decimal_in(d3), .loop4_decimal_in(d4), .loop3_setting_err_in(e3),
    .loop4_setting_err_in(e4), .host_out_word_n2_in(n2),
    .save_start_out(ss), .save_done_in(sd), .sensor_absent_in(ab),
    .sensor_broken_in(br), .sensor_overrange_in(ov),
    .cold_junction_fault_in(cj), .host_watchdog_timer_err_in(wd),
    .autotune_update_in(at), .change_pid_req_in(cp), .pid_load_out(pl),
    .pid_pending_out(pp), .loop3_pv_word_out(pvw));
  host_cpu_model i_host_cpu_model (.sys_clk_in(clk), .save_req_in(sq),
    .save_start_in(ss), .dly_in(dly), .host_word_out(n2),
    .save_done_out(sd));
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic chk(string n, logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s exp %h got %h", n, exp, got);
    end
  endtask
  task automatic rdw(logic [7:0] a, logic [15:0] exp, string n);
    addr = a;
    repeat (2) @(negedge clk);
    chk(n, rd, exp);
  endtask
  task automatic end_sim();
    if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge clk);
    chk("rst", rd, 16'h0000);
    rst_n = 1;
    rdw(OFS_LOOP3_STATUS_FLAGS, 16'h0800, "standby");
    rf = 1;
    @(negedge clk);
    rf = 0;
    rdw(OFS_LOOP3_STATUS_FLAGS, 16'h0000, "refresh");
    foreach (rows[i]) begin
      {fmt, sp, d3, d4, e3, e4, ab, br, ov, cj, wd} =
        {rows[i].f, rows[i].sp, rows[i].dec, rows[i].er};
      rdw(OFS_LOOP4_SET_POINT, rows[i].xsp, "sp");
      rdw(OFS_DECIMAL_AND_SETTING_ERROR, rows[i].dec, "dec");
      rdw(OFS_LOOP3_STATUS_FLAGS, rows[i].xst, "stat");
      if (ov) chk("pv", pvw, PV_RANGE_ERR);
      else chk("pvenc", pvw, rows[i].xsp);
    end
    {ab, br, ov, cj, wd} = 5'h00;
    rdw(8'h13, 16'h0000, "unmapped");
    for (int k = 0; k < 2; k++) begin
      dly = k ? 4'h5 : 4'h1;
      sq = 1;
      for (int i = 0; i < 20 && ss !== 1'b1; i++) @(negedge clk);
      if (ss !== 1'b1) begin
        failures++;
        end_sim();
      end
      rdw(OFS_LOOP3_STATUS_FLAGS, 16'h0000, "save clr");
      chk("pulse", {15'h0000, ss}, 16'h0000);
      repeat (10) @(negedge clk);
      rdw(OFS_LOOP3_STATUS_FLAGS, 16'h8000, "saved");
      sq = 0;
      @(negedge clk);
    end
    at = 1;
    @(negedge clk);
    at = 0;
    chk("pend", {15'h0000, pp}, 16'h0001);
    rdw(OFS_LOOP3_STATUS_FLAGS, 16'h8400, "pidflag");
    cp = 1;
    @(negedge clk);
    chk("load", {15'h0000, pl}, 16'h0001);
    chk("pend0", {15'h0000, pp}, 16'h0000);
    cp = 0;
    en = 0;
    at = 1;
    repeat (2) @(negedge clk);
    chk("frozen", {15'h0000, pp}, 16'h0000);
    at = 0;
    en = 1;
    rs = 1;
    @(negedge clk);
    rs = 0;
    rdw(OFS_LOOP3_STATUS_FLAGS, 16'h8800, "restart");
    rst_n = 0;
    repeat (2) @(negedge clk);
    rst_n = 1;
    rdw(OFS_LOOP3_STATUS_FLAGS, 16'h0800, "reset2");
    end_sim();
  end
endmodule
